//--- src/ssi_indicator.sv
// indicator and switch status logic of the ultrasonic sensor
`timescale 1ns/100ps
module ssi_indicator
  import ssi_pkg::*;
(
  // all inputs are levels sampled on the clock, except the event pulses
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // mode and control
  input wire ssi_ctl_s ctl_in,
  input wire ssi_sw_s sw_cfg_in,
  input wire logic sel_load_in,
  input wire ssi_sel_e sq_sel_in,
  input wire ssi_sel_e rect_sel_in,
  // measurement
  input wire logic target_in,
  input wire logic near_min_in,
  input wire logic [DIST_W-1:0] dist_in,
  input wire logic [DIST_W-1:0] span_lo_in,
  input wire logic [DIST_W-1:0] span_hi_in,
  input wire logic [1:0][DIST_W-1:0] setpoint_in,
  // events
  input wire logic rx_byte_in,
  input wire logic tx_reply_in,
  input wire logic tx_stream_in,
  input wire logic ref_seen_in,
  // indicators and outputs
  output logic led_red_out,
  output logic led_green_out,
  output logic led_sq_out,
  output logic led_rect_out,
  output logic [1:0] switch_on_out,
  output logic filters_en_out,
  output logic measure_en_out,
  output logic analog_hold_out
);

  ////////////////////////////////////////////////////////////
  // pattern timebase
  // two free-running counters serve the blink patterns; the slow and double blinks share the slow one, so all
  // indicators that blink slowly do so in step with one another
  logic [CNT_W-1:0] slow_q, slow_d;   // slow half period counter
  logic [CNT_W-1:0] fast_q, fast_d;   // fast half period counter
  logic [PH_W-1:0] ph_q, ph_d;        // slow phase index
  logic fast_ph_q, fast_ph_d;         // fast toggle
  logic slow_tick;
  logic fast_tick;

  // fixed counters give each pattern its own period
  always_comb begin
    slow_tick = (slow_q == CNT_W'(SLOW_HALF_CYC - 1));
    fast_tick = (fast_q == CNT_W'(FAST_HALF_CYC - 1));
    slow_d = slow_tick ? '0 : slow_q + CNT_W'(1);
    fast_d = fast_tick ? '0 : fast_q + CNT_W'(1);
    ph_d = slow_tick ? ph_q + PH_W'(1) : ph_q;
    fast_ph_d = fast_tick ? ~fast_ph_q : fast_ph_q;
  end

  // timebase registers; the timebase runs from reset, so blink phases
  // are repeatable from one power-up to the next
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      slow_q <= '0;
      fast_q <= '0;
      ph_q <= '0;
      fast_ph_q <= 1'b0;
    end else begin
      slow_q <= slow_d;
      fast_q <= fast_d;
      ph_q <= ph_d;
      fast_ph_q <= fast_ph_d;
    end
  end

  // pattern levels: high means the lit half of the pattern; both start
  // lit after reset because the phase index starts at zero
  logic slow_on;
  logic dbl_on;
  assign slow_on = ~ph_q[0];        // single slow blink
  assign dbl_on = DBL_MASK[ph_q];   // double blink, repeats every eight phases

  ////////////////////////////////////////////////////////////
  // target indicator
  // the no-sync warning is a small state machine; it leaves on sync
  // return, on button use or when the unit stops being a slave
  ssi_tgt_e tstate_q, tstate_d;
  logic red_d, green_d;
  logic fb_allowed;

  // teach feedback suppressed only when disabled and no sync role
  assign fb_allowed = ~(ctl_in.adjust_disabled & ~ctl_in.sync_master & ~ctl_in.sync_slave);

  // sync loss state; left on sync return or button use
  always_comb begin
    tstate_d = tstate_q;
    case (tstate_q)
      SSI_T_NORMAL: begin
        if (ctl_in.sync_slave && !ctl_in.sync_present && !ctl_in.button_held) begin
          tstate_d = SSI_T_NOSYNC;
        end
      end
      SSI_T_NOSYNC: begin
        if (ctl_in.sync_present || ctl_in.button_held || !ctl_in.sync_slave) begin
          tstate_d = SSI_T_NORMAL;
        end
      end
      default: tstate_d = SSI_T_NORMAL;
    endcase
  end

  // colour selection by priority: feedback, no sync, unlocked, target
  // the unlocked blink never changes the colour, it only blanks the lit colour
  // during the dark half of the chosen pattern
  always_comb begin
    red_d = 1'b0;
    green_d = 1'b0;
    if (ctl_in.button_held && fb_allowed) begin
      // operator counts these red flashes
      red_d = ctl_in.alternate_adjust_mode ? dbl_on : slow_on;
    end else if (tstate_q == SSI_T_NOSYNC) begin
      red_d = slow_on;   // alternate red and green
      green_d = ~slow_on;
    end else begin
      if (target_in) begin
        // near minimum range the green flashes fast
        green_d = near_min_in ? fast_ph_q : 1'b1;
      end else begin
        red_d = 1'b1;
      end
      if (ctl_in.unlocked) begin
        // colour kept, gated by blink pattern
        if (ctl_in.alternate_adjust_mode ? !dbl_on : !slow_on) begin
          red_d = 1'b0;
          green_d = 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // switches and no-target timer
  // the no-target timer saturates at its limit instead of wrapping, so
  // a long absence cannot switch the outputs back on
  // limitation: the timer restarts on any single cycle with a target
  logic [CNT_W-1:0] nt_q, nt_d;  // no target duration
  logic nt_off;
  logic [1:0] sw_d, sw_q;

  always_comb begin
    nt_d = target_in ? '0 : (nt_q == CNT_W'(NOTGT_OFF_CYC)) ? nt_q : nt_q + CNT_W'(1);
    nt_off = sw_cfg_in.no_tgt_switch_off && (nt_q == CNT_W'(NOTGT_OFF_CYC));
  end

  // per switch: polarity, fault shutdown and no-target turn-off
  // equal distance counts as farther; the setpoint itself is not closer
  for (genvar i = 0; i < 2; i++) begin : g_sw
    logic closer;
    assign closer = dist_in < setpoint_in[i];
    // conduction only, sink or source alike
    assign sw_d[i] = (sw_cfg_in.on_farther[i] ? !closer : closer)
      && !sw_cfg_in.fault[i] && !nt_off; // fault off, resumes when cleared
  end

  ////////////////////////////////////////////////////////////
  // status indicator sources
  // flash stretch state, one set per serial direction
  logic rx_fl_q, rx_fl_d, tx_fl_q, tx_fl_d;
  logic [CNT_W-1:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d;
  logic analog_st;
  logic [1:0] sw_st;
  ssi_sel_e sq_sel_q, sq_sel_d, rect_sel_q, rect_sel_d;
  logic sq_d, rect_d;

  // a single cycle pulse would be invisible to the eye, so each event
  // reloads a counter; back to back events simply retrigger it
  // flash stretchers so single byte events are visible
  always_comb begin
    rx_cnt_d = rx_cnt_q;
    tx_cnt_d = tx_cnt_q;
    if (rx_byte_in) begin
      rx_cnt_d = CNT_W'(FLASH_CYC); // any data, valid or not
    end else if (rx_cnt_q != '0) begin
      rx_cnt_d = rx_cnt_q - CNT_W'(1);
    end
    if (tx_reply_in || tx_stream_in) begin
      tx_cnt_d = CNT_W'(FLASH_CYC);
    end else if (tx_cnt_q != '0) begin
      tx_cnt_d = tx_cnt_q - CNT_W'(1);
    end
    rx_fl_d = rx_cnt_d != '0;
    tx_fl_d = tx_cnt_d != '0;
  end

  // analog span display: on inside, off low, blink high
  // low end is tested first, so a distance equal to both endpoints of a span reads off
  // blinking uses the fast pattern, since the high end warns of range
  always_comb begin
    if (dist_in <= span_lo_in) begin
      analog_st = 1'b0;
    end else if (dist_in >= span_hi_in) begin
      analog_st = fast_ph_q;
    end else begin
      analog_st = 1'b1;
    end
  end

  // switch status, blinking while in safe shutdown
  // the fault blink uses the slow pattern
  for (genvar j = 0; j < 2; j++) begin : g_st
    assign sw_st[j] = sw_cfg_in.fault[j] ? slow_on : sw_q[j];
  end

  // selection load; unavailable choices turn that indicator off
  // an unavailable choice is refused at load time; the indicator then
  // stays dark until a valid choice is loaded again
  // limitation: the check is not repeated if the mode changes later
  always_comb begin
    sq_sel_d = sq_sel_q;
    rect_sel_d = rect_sel_q;
    if (sel_load_in) begin
      sq_sel_d = sq_sel_in;
      rect_sel_d = rect_sel_in;
      if ((sq_sel_in == SSI_SEL_SWITCH && !sw_cfg_in.out1_is_switch) ||
          (sq_sel_in == SSI_SEL_REF && !sw_cfg_in.ref_comp_mode)) begin
        sq_sel_d = SSI_SEL_OFF;
      end
      if (rect_sel_in == SSI_SEL_REF && !sw_cfg_in.ref_comp_mode) begin
        rect_sel_d = SSI_SEL_OFF;
      end
    end
  end

  // source mux; square shows switch one, rectangle switch two
  // off and any code outside the list leave the indicator dark
  always_comb begin
    case (sq_sel_q)
      SSI_SEL_ANALOG: sq_d = analog_st;
      SSI_SEL_SWITCH: sq_d = sw_st[0];
      SSI_SEL_RX: sq_d = rx_fl_q;
      SSI_SEL_TX: sq_d = tx_fl_q;
      SSI_SEL_REF: sq_d = ref_seen_in;
      default: sq_d = 1'b0;
    endcase
    case (rect_sel_q)
      SSI_SEL_ANALOG: rect_d = analog_st;
      SSI_SEL_SWITCH: rect_d = sw_st[1];
      SSI_SEL_RX: rect_d = rx_fl_q;
      SSI_SEL_TX: rect_d = tx_fl_q;
      SSI_SEL_REF: rect_d = ref_seen_in;
      default: rect_d = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////
  // output and state registers
  // every operator visible output is registered so that the pins never
  // show combinational glitches between patterns
  // reset lights nothing, keeps filtering and measuring enabled
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tstate_q <= SSI_T_NORMAL;
      nt_q <= '0;
      sw_q <= '0;
      rx_cnt_q <= '0;
      tx_cnt_q <= '0;
      rx_fl_q <= 1'b0;
      tx_fl_q <= 1'b0;
      sq_sel_q <= SQ_DEFAULT;   // model default
      rect_sel_q <= RECT_DEFAULT;
      led_red_out <= 1'b0;
      led_green_out <= 1'b0;
      led_sq_out <= 1'b0;
      led_rect_out <= 1'b0;
      switch_on_out <= '0;
      filters_en_out <= 1'b1;
      measure_en_out <= 1'b1;
      analog_hold_out <= 1'b0;
    end else begin
      tstate_q <= tstate_d;
      nt_q <= nt_d;
      sw_q <= sw_d;
      rx_cnt_q <= rx_cnt_d;
      tx_cnt_q <= tx_cnt_d;
      rx_fl_q <= rx_fl_d;
      tx_fl_q <= tx_fl_d;
      sq_sel_q <= sq_sel_d;
      rect_sel_q <= rect_sel_d;
      led_red_out <= red_d;
      led_green_out <= green_d;
      led_sq_out <= sq_d;
      led_rect_out <= rect_d;
      switch_on_out <= sw_d;
      filters_en_out <= !ctl_in.unlocked;
      measure_en_out <= (tstate_d != SSI_T_NOSYNC);
      analog_hold_out <= !target_in;                  // hold last value
    end
  end

endmodule

//--- src/ssi_pkg.sv
// package of constants and types for the sensor status indicator logic
package ssi_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // pattern half periods, flash length and no-target limit in microseconds
  localparam int unsigned SLOW_HALF_US = 500000;
  localparam int unsigned FAST_HALF_US = 62500;
  localparam int unsigned FLASH_US = 50000;
  localparam int unsigned NOTGT_OFF_US = 1000000;
  localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_US * CLK_MHZ;
  localparam int unsigned FAST_HALF_CYC = FAST_HALF_US * CLK_MHZ;
  localparam int unsigned FLASH_CYC = FLASH_US * CLK_MHZ;
  localparam int unsigned NOTGT_OFF_CYC = NOTGT_OFF_US * CLK_MHZ;
  localparam int CNT_W = 28;
  localparam int PH_W = 3;
  localparam int DIST_W = 16;
  localparam logic [PH_W-1:0] PH_LAST = 3'h7;
  // double blink: on, off, on, then five off phases of eight
  localparam logic [7:0] DBL_MASK = 8'h05;
  typedef enum logic [2:0] {SSI_SEL_OFF, SSI_SEL_ANALOG, SSI_SEL_SWITCH, SSI_SEL_RX, SSI_SEL_TX,
    SSI_SEL_REF} ssi_sel_e;
  localparam ssi_sel_e SQ_DEFAULT = SSI_SEL_ANALOG;
  localparam ssi_sel_e RECT_DEFAULT = SSI_SEL_TX;
  typedef struct packed {
    logic unlocked;
    logic alternate_adjust_mode;
    logic button_held;
    logic adjust_disabled;
    logic sync_master;
    logic sync_slave;
    logic sync_present;
  } ssi_ctl_s;
  typedef struct packed {
    logic [1:0] fault;      // over-current or over-temperature per switch
    logic [1:0] on_farther; // polarity per switch
    logic out1_is_switch;
    logic ref_comp_mode;
    logic no_tgt_switch_off;
  } ssi_sw_s;
  typedef enum logic [1:0] {SSI_T_NORMAL, SSI_T_NOSYNC} ssi_tgt_e;
endpackage

//--- testbench/ssi_checker_props.sv
// assertions on the indicator block ports
`timescale 1ns/100ps
module ssi_checker
  import ssi_pkg::*;
(
  // clock, reset and watched inputs
  input wire logic ref_clk_in, rst_in, target_in, near_min_in,
  input wire ssi_ctl_s ctl_in,
  input wire ssi_sw_s sw_cfg_in,
  input wire logic [DIST_W-1:0] dist_in,
  input wire logic [1:0][DIST_W-1:0] setpoint_in,
  // watched outputs
  input wire logic led_red_out, led_green_out, filters_en_out, measure_en_out, analog_hold_out,
  input wire logic [1:0] switch_on_out
);
  // the edge that releases reset still shows reset values on the outputs
  logic rst_q;
  always_ff @(posedge ref_clk_in) begin
    rst_q <= rst_in;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in || rst_q);
  // steady target display, no blink or override source active
  wire plain = !ctl_in.unlocked && !ctl_in.button_held && !ctl_in.sync_slave && !near_min_in;
  wire excl = ctl_in.adjust_disabled && !ctl_in.sync_master && !ctl_in.sync_slave;
  property p_grn; plain && $past(plain) && target_in |=> led_green_out && !led_red_out; endproperty
  a_grn: assert property (p_grn) else $error("target colour not green");
  property p_red; plain && $past(plain) && !target_in |=> led_red_out && !led_green_out; endproperty
  a_red: assert property (p_red) else $error("no-target colour not red");
  property p_btn; ctl_in.button_held && !excl |=> !led_green_out; endproperty
  a_btn: assert property (p_btn) else $error("green during button feedback");
  property p_filt; ctl_in.unlocked |=> !filters_en_out; endproperty
  a_filt: assert property (p_filt) else $error("filters on while unlocked");
  property p_stop; ctl_in.sync_slave && !ctl_in.sync_present && !ctl_in.button_held |-> ##1 !measure_en_out;
  endproperty
  a_stop: assert property (p_stop) else $error("measuring without sync");
  property p_meas; !ctl_in.sync_slave || ctl_in.sync_present |=> measure_en_out; endproperty
  a_meas: assert property (p_meas) else $error("measuring not resumed");
  property p_hold; !target_in [*2] |-> analog_hold_out; endproperty
  a_hold: assert property (p_hold) else $error("analog not held");
  property p_flt; sw_cfg_in.fault[0] |=> !switch_on_out[0]; endproperty
  a_flt: assert property (p_flt) else $error("switch on during fault");
  property p_sw; target_in && $past(target_in) && !sw_cfg_in.fault[1] && dist_in != setpoint_in[1] &&
    ((dist_in < setpoint_in[1]) != sw_cfg_in.on_farther[1]) |=> switch_on_out[1]; endproperty
  a_sw: assert property (p_sw) else $error("switch two not on");
endmodule

//--- testbench/ssi_operator.sv
// operator model: holds the adjust button and counts red flashes
`timescale 1ns/100ps
module ssi_operator (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic press_in,
  input wire logic led_red_in,
  input wire logic [3:0] want_in,
  output logic button_out
);
  logic [3:0] cnt_q;
  logic red_q;
  // count red rising edges while held
  always_ff @(posedge ref_clk_in) begin
    red_q <= led_red_in;
    if (rst_in || !press_in) begin
      cnt_q <= 4'h0;
    end else if (led_red_in && !red_q && button_out) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // let go once the wanted count is seen
  assign button_out = press_in && (cnt_q < want_in);
endmodule

//--- testbench/tb.sv
// bench: random stimulus compared with a behavioural model
`timescale 1ns/100ps
module tb;
  import ssi_pkg::*;
  logic ref_clk_in = 0, rst_in = 1, sel_load_in = 0, target_in = 0, near_min_in = 0, ref_seen_in = 0;
  logic rx_byte_in = 0, tx_reply_in = 0, tx_stream_in = 0, press_q = 0, button;
  ssi_ctl_s ctl_v = '0, ctl_w;
  ssi_sw_s sw_cfg_in = '0;
  ssi_sel_e sq_sel_in = SSI_SEL_OFF, rect_sel_in = SSI_SEL_OFF, sq_m = SQ_DEFAULT, rc_m = RECT_DEFAULT;
  logic [DIST_W-1:0] dist_in = '0, span_lo_in = '0, span_hi_in = '0;
  logic [1:0][DIST_W-1:0] setpoint_in = '0;
  logic led_red_out, led_green_out, led_sq_out, led_rect_out, filters_en_out, measure_en_out, analog_hold_out;
  logic [1:0] switch_on_out;
  bit rx_m = 0, tx_m = 0;
  int n_errors = 0, samples_checked = 0, cycles = 0;
  always_comb begin
    ctl_w = ctl_v;
    ctl_w.button_held = button;
  end
  ssi_indicator dut_u (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ctl_in(ctl_w), .sw_cfg_in(sw_cfg_in), .sel_load_in(sel_load_in),
    .sq_sel_in(sq_sel_in), .rect_sel_in(rect_sel_in), .target_in(target_in), .near_min_in(near_min_in),
    .dist_in(dist_in), .span_lo_in(span_lo_in), .span_hi_in(span_hi_in), .setpoint_in(setpoint_in),
    .rx_byte_in(rx_byte_in), .tx_reply_in(tx_reply_in), .tx_stream_in(tx_stream_in), .ref_seen_in(ref_seen_in),
    .led_red_out(led_red_out), .led_green_out(led_green_out), .led_sq_out(led_sq_out), .led_rect_out(led_rect_out),
    .switch_on_out(switch_on_out), .filters_en_out(filters_en_out), .measure_en_out(measure_en_out),
    .analog_hold_out(analog_hold_out));
  ssi_operator op_u (.ref_clk_in, .rst_in, .press_in(press_q), .led_red_in(led_red_out), .want_in(4'h3),
    .button_out(button));
  initial forever #2 ref_clk_in = ~ref_clk_in;
  // hang guard, far above the sixty short steps
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic check(logic seen, logic exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: output %b, model %b", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic sw_x(int i);
    return !sw_cfg_in.fault[i] && ((dist_in < setpoint_in[i]) != sw_cfg_in.on_farther[i]);
  endfunction
  // model of one status indicator; stimulus keeps distance below the high end
  function automatic logic led_x(ssi_sel_e s, int i);
    case (s)
      SSI_SEL_ANALOG: return dist_in > span_lo_in;
      SSI_SEL_SWITCH: return sw_cfg_in.fault[i] || sw_x(i);
      SSI_SEL_RX: return rx_m;
      SSI_SEL_TX: return tx_m;
      SSI_SEL_REF: return ref_seen_in;
      default: return 1'b0;
    endcase
  endfunction
  // one random setting, then compare every output, the colours skipped when no sync meets a held button; slow blinks are still lit, the fast flash dark
  task automatic step(int k);
    ssi_sw_s sw;
    ssi_sel_e sq, rc;
    logic [DIST_W-1:0] lo, d;
    logic [1:0][DIST_W-1:0] sp;
    logic [2:0] ev;
    bit btn, ns, b1, b;
    sw = ssi_sw_s'(7'($urandom));
    if ($urandom_range(3) != 0) sw.fault = '0;
    sq = ssi_sel_e'(3'($urandom_range(5)));
    rc = ssi_sel_e'(3'($urandom_range(5)));
    lo = DIST_W'($urandom_range(16'h4000, 16'h0020));
    d = ($urandom_range(7) == 0) ? lo : DIST_W'($urandom_range(16'h7FDF, 16'h0020));
    ev = ($urandom_range(3) == 0) ? 3'($urandom) : 3'h0;
    if (k == 0) begin
      d = lo + 16'h0001;
      ev = 3'h2;
    end
    for (int i = 0; i < 2; i++) sp[i] = $urandom_range(1) ? d + 16'h0010 : d - 16'h0010;
    @(posedge ref_clk_in);
    ctl_v <= ssi_ctl_s'(7'($urandom));
    press_q <= 1'($urandom);
    sw_cfg_in <= sw;
    sel_load_in <= (k != 0);
    sq_sel_in <= sq;
    rect_sel_in <= rc;
    target_in <= 1'($urandom);
    near_min_in <= ($urandom_range(3) == 0);
    ref_seen_in <= 1'($urandom);
    dist_in <= d;
    span_lo_in <= lo;
    span_hi_in <= 16'h8000;
    setpoint_in <= sp;
    {rx_byte_in, tx_reply_in, tx_stream_in} <= ev;
    rx_m |= ev[2];
    tx_m |= ev[1] | ev[0];
    if (k != 0) begin
      sq_m = ((sq == SSI_SEL_SWITCH && !sw.out1_is_switch) || (sq == SSI_SEL_REF && !sw.ref_comp_mode)) ?
        SSI_SEL_OFF : sq;
      rc_m = (rc == SSI_SEL_REF && !sw.ref_comp_mode) ? SSI_SEL_OFF : rc;
    end
    // button levels as the design samples them at the next two edges
    #1;
    b1 = button;
    @(posedge ref_clk_in);
    sel_load_in <= 1'h0;
    {rx_byte_in, tx_reply_in, tx_stream_in} <= 3'h0;
    #1;
    b = button;
    @(posedge ref_clk_in);
    #1;
    btn = b && !(ctl_w.adjust_disabled && !ctl_w.sync_master && !ctl_w.sync_slave);
    ns = ctl_w.sync_slave && !ctl_w.sync_present && !b;
    for (int i = 0; i < 2; i++) check(switch_on_out[i], sw_x(i));
    check(filters_en_out, !ctl_w.unlocked);
    check(measure_en_out, !ns);
    check(analog_hold_out, !target_in);
    if (!ns) begin
      check(led_red_out, btn || !target_in);
      // the fast flash opens with its dark half
      check(led_green_out, !btn && target_in && !near_min_in);
    end else if (!b1) begin
      // no-sync alternation opens on red
      check(led_red_out, 1'b1);
      check(led_green_out, 1'b0);
    end
    check(led_sq_out, led_x(sq_m, 0));
    check(led_rect_out, led_x(rc_m, 1));
  endtask
  initial begin
    void'($urandom(48416));
    repeat (15) @(posedge ref_clk_in);
    #1;
    check(led_green_out | led_red_out | led_sq_out | led_rect_out, 1'h0);
    check(filters_en_out & measure_en_out & !analog_hold_out, 1'h1);
    @(posedge ref_clk_in);
    rst_in <= 1'h0;
    for (int k = 0; k < 60; k++) step(k);
    wrap_up();
  end
endmodule
bind ssi_indicator ssi_checker chk_u (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .target_in(target_in), .near_min_in(near_min_in), .ctl_in(ctl_in),
  .sw_cfg_in(sw_cfg_in), .dist_in(dist_in), .setpoint_in(setpoint_in), .led_red_out(led_red_out),
  .led_green_out(led_green_out), .filters_en_out(filters_en_out), .measure_en_out(measure_en_out),
  .analog_hold_out(analog_hold_out), .switch_on_out(switch_on_out));
